// file: floppy_step_head_load_control.sv
module floppy_step_head_load_control #(
  parameter int unsigned SETTLE_CYC = head_pos_pkg::SETTLE_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_N0_CYC = head_pos_pkg::RATE_N0_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_N1_CYC = head_pos_pkg::RATE_N1_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_N2_CYC = head_pos_pkg::RATE_N2_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_N3_CYC = head_pos_pkg::RATE_N3_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_T0_CYC = head_pos_pkg::RATE_T0_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_T1_CYC = head_pos_pkg::RATE_T1_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_T2_CYC = head_pos_pkg::RATE_T2_NS / head_pos_pkg::CLK_NS,
  parameter int unsigned RATE_T3_CYC = head_pos_pkg::RATE_T3_NS / head_pos_pkg::CLK_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rdata,
  // Drive and mode inputs.
  input wire logic test_n,
  input wire logic density_select_input,
  input wire logic ready,
  input wire logic index_pulse,
  input wire logic track_zero,
  input wire logic head_engaged_input,
  // ID field results from the read channel.
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic id_crc_ok,
  input wire logic [1:0] id_length_code,
  input wire logic xfer_done,
  // Drive outputs.
  output logic step_pulse,
  output logic direction,
  output logic head_engage_output,
  // Controller outputs.
  output logic completion_interrupt,
  output logic medium_enable,
  output logic side_compare_value,
  output logic multi_record,
  output logic [10:0] sector_bytes
);

  // Sequencer state and the command being executed.
  head_pos_pkg::seq_state_t state;
  logic [7:0] cmd;
  logic busy;
  logic crc_err;
  logic seek_err;
  logic done_evt; // One-cycle pulse when a command completes.
  logic [31:0] timer; // Down counter shared by all delays.
  logic [31:0] width_cyc; // Step pulse width latched at command start.
  logic [7:0] step_cnt; // Steps issued by this command.
  logic [2:0] rev_cnt; // Index pulses seen while verifying.
  logic [7:0] track;
  logic [7:0] sector;
  logic [7:0] data;
  logic [3:0] idle_cnt; // Index pulses while idle with the head loaded.
  logic [3:0] force_cond; // Armed force-interrupt conditions.
  logic ready_q; // Ready from the previous cycle for edge detection.

  // Decode of the register port.
  logic cmd_wr;
  logic force_wr;
  logic start_wr;
  logic status_rd;
  logic idle_unload;
  logic [7:0] status;
  logic head_on;

  // A command write during busy is dropped unless it is a force interrupt.
  assign cmd_wr = wr_strobe && (addr == head_pos_pkg::ADDR_CMD);
  assign force_wr = cmd_wr && (wdata[7:4] == 4'hd);
  assign start_wr = cmd_wr && !force_wr && !busy;
  assign status_rd = rd_strobe && (addr == head_pos_pkg::ADDR_CMD);
  assign head_on = head_engage_output && head_engaged_input;
  assign idle_unload = !busy && head_engage_output && index_pulse && (idle_cnt == head_pos_pkg::IDLE_INDEX - 4'h1);

  // Medium access needs the head loaded and engaged at once.
  assign medium_enable = (state == head_pos_pkg::ST_XFER) && head_on;

  // Status word; bit 5 shows load and engaged after positioning commands.
  always_comb begin
    status = 8'h00;
    status[head_pos_pkg::ST_BUSY] = busy;
    status[head_pos_pkg::ST_CRC] = crc_err;
    status[head_pos_pkg::ST_SEEK] = seek_err;
    status[head_pos_pkg::ST_HEAD] = !cmd[7] && head_on;
  end

  // Step interval from the rate field; test mode uses the short table.
  function automatic logic [31:0] rate_cycles(input logic tn, input logic [1:0] r);
    logic [31:0] res;
    res = 32'h0;
    case (r)
      2'h0: res = tn ? RATE_N0_CYC : RATE_T0_CYC;
      2'h1: res = tn ? RATE_N1_CYC : RATE_T1_CYC;
      2'h2: res = tn ? RATE_N2_CYC : RATE_T2_CYC;
      default: res = tn ? RATE_N3_CYC : RATE_T3_CYC;
    endcase
    return res;
  endfunction

  // Main sequencer: stepping, settling, engage wait, verify and transfer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= head_pos_pkg::ST_IDLE;
      cmd <= 8'h00;
      busy <= 1'b0;
      crc_err <= 1'b0;
      seek_err <= 1'b0;
      done_evt <= 1'b0;
      timer <= 32'h0;
      width_cyc <= 32'h0;
      step_cnt <= 8'h00;
      rev_cnt <= 3'h0;
      track <= 8'h00;
      step_pulse <= 1'b0;
      direction <= 1'b0;
      head_engage_output <= 1'b0;
      side_compare_value <= 1'b0;
      multi_record <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (wr_strobe && addr == head_pos_pkg::ADDR_TRACK && !busy) begin
        track <= wdata;
      end
      if (force_wr) begin
        // A force interrupt ends any command at once.
        state <= head_pos_pkg::ST_IDLE;
        busy <= 1'b0;
        step_pulse <= 1'b0;
      end else begin
        case (state)
          head_pos_pkg::ST_IDLE: begin
            // Long idle with the head loaded drops it.
            if (idle_unload) begin
              head_engage_output <= 1'b0;
            end
            if (start_wr) begin
              cmd <= wdata;
              crc_err <= 1'b0;
              seek_err <= 1'b0;
              step_cnt <= 8'h00;
              width_cyc <= density_select_input ? head_pos_pkg::STEP_SD_CYC
                                                : head_pos_pkg::STEP_DD_CYC;
              if (!wdata[7]) begin
                busy <= 1'b1;
                // Head flag loads now; both flags clear unloads.
                if (wdata[head_pos_pkg::HEAD_BIT]) begin
                  head_engage_output <= 1'b1;
                end else if (!wdata[head_pos_pkg::VERIFY_BIT]) begin
                  head_engage_output <= 1'b0;
                end
                state <= head_pos_pkg::ST_PLAN;
              end else if (!ready) begin
                // Read or write refused on a drive that is not ready.
                done_evt <= 1'b1;
              end else begin
                busy <= 1'b1;
                head_engage_output <= 1'b1;
                side_compare_value <= wdata[head_pos_pkg::SIDE_BIT];
                multi_record <= wdata[head_pos_pkg::MULTI_BIT];
                timer <= SETTLE_CYC;
                state <= wdata[head_pos_pkg::DELAY_BIT] ? head_pos_pkg::ST_SETTLE
                                                        : head_pos_pkg::ST_ENGAGE;
              end
            end
          end
          head_pos_pkg::ST_PLAN: begin
            // Decide whether another step is due and in which direction.
            if (cmd[6:4] == 3'h0 && track_zero) begin
              track <= 8'h00;
            end
            if ((cmd[6:4] == 3'h0 && !track_zero && step_cnt != head_pos_pkg::MAX_STEPS) ||
                (cmd[6:4] == 3'h1 && track != data) ||
                (cmd[6:5] != 2'h0 && step_cnt == 8'h00)) begin
              // High steps inward; a plain step keeps the last direction.
              if (cmd[6:4] == 3'h0 || cmd[6:5] == 2'h3) begin
                direction <= 1'b0;
              end else if (cmd[6:5] == 2'h2) begin
                direction <= 1'b1;
              end else if (cmd[6:4] == 3'h1) begin
                direction <= (data > track);
              end
              timer <= head_pos_pkg::DIR_SETUP_CYC;
              state <= (step_cnt == 8'h00) ? head_pos_pkg::ST_DIR : head_pos_pkg::ST_STEP_HI;
              if (step_cnt != 8'h00) begin
                step_pulse <= 1'b1;
                timer <= width_cyc - 32'h1;
              end
            end else if (cmd[6:4] == 3'h0 && !track_zero) begin
              // Track zero never seen after the full step budget.
              seek_err <= 1'b1;
              busy <= 1'b0;
              done_evt <= 1'b1;
              state <= head_pos_pkg::ST_IDLE;
            end else if (cmd[head_pos_pkg::VERIFY_BIT]) begin
              // Verify loads the head now and settles, none in test mode.
              head_engage_output <= 1'b1;
              timer <= test_n ? SETTLE_CYC : 32'h0;
              state <= head_pos_pkg::ST_SETTLE;
            end else begin
              busy <= 1'b0;
              done_evt <= 1'b1;
              state <= head_pos_pkg::ST_IDLE;
            end
          end
          head_pos_pkg::ST_DIR: begin
            // Direction stands steady before the first pulse.
            if (timer != 32'h0) begin
              timer <= timer - 32'h1;
            end else begin
              step_pulse <= 1'b1;
              timer <= width_cyc - 32'h1;
              state <= head_pos_pkg::ST_STEP_HI;
            end
          end
          head_pos_pkg::ST_STEP_HI: begin
            if (timer != 32'h0) begin
              timer <= timer - 32'h1;
            end else begin
              step_pulse <= 1'b0;
              step_cnt <= step_cnt + 8'h01;
              // Seek and restore always track; step types on update flag.
              if (cmd[6:5] == 2'h0 || cmd[head_pos_pkg::UPDATE_BIT]) begin
                track <= direction ? track + 8'h01 : track - 8'h01;
              end
              timer <= rate_cycles(test_n, cmd[head_pos_pkg::RATE_LO +: 2]);
              state <= head_pos_pkg::ST_STEP_WAIT;
            end
          end
          head_pos_pkg::ST_STEP_WAIT: begin
            // Step interval before the next decision.
            if (timer != 32'h0) begin
              timer <= timer - 32'h1;
            end else begin
              state <= head_pos_pkg::ST_PLAN;
            end
          end
          head_pos_pkg::ST_SETTLE: begin
            if (timer != 32'h0) begin
              timer <= timer - 32'h1;
            end else begin
              state <= head_pos_pkg::ST_ENGAGE;
            end
          end
          head_pos_pkg::ST_ENGAGE: begin
            // The engaged input is sampled until it comes true.
            if (head_engaged_input) begin
              rev_cnt <= 3'h0;
              state <= cmd[7] ? head_pos_pkg::ST_XFER : head_pos_pkg::ST_VERIFY;
            end
          end
          head_pos_pkg::ST_VERIFY: begin
            // First matching ID with good CRC completes; a CRC error flagged earlier stays set.
            if (id_valid && id_track == track && id_crc_ok) begin
              busy <= 1'b0;
              done_evt <= 1'b1;
              state <= head_pos_pkg::ST_IDLE;
            end else if (index_pulse && rev_cnt == head_pos_pkg::VERIFY_REVS - 3'h1) begin
              seek_err <= 1'b1;
              busy <= 1'b0;
              done_evt <= 1'b1;
              state <= head_pos_pkg::ST_IDLE;
            end else begin
              if (id_valid && id_track == track) begin
                crc_err <= 1'b1;
              end
              if (index_pulse) begin
                rev_cnt <= rev_cnt + 3'h1;
              end
            end
          end
          head_pos_pkg::ST_XFER: begin
            // The data path signals the end of the transfer.
            if (xfer_done) begin
              busy <= 1'b0;
              done_evt <= 1'b1;
              state <= head_pos_pkg::ST_IDLE;
            end
          end
          default: begin
            state <= head_pos_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Sector and data registers written by software.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sector <= 8'h00;
      data <= 8'h00;
    end else if (wr_strobe && addr == head_pos_pkg::ADDR_SECTOR) begin
      sector <= wdata;
    end else if (wr_strobe && addr == head_pos_pkg::ADDR_DATA) begin
      data <= wdata;
    end
  end

  // Sector size from each ID field seen while the last command started is a sector command.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sector_bytes <= head_pos_pkg::BYTES_256;
    end else if (id_valid && cmd[7]) begin
      sector_bytes <= head_pos_pkg::length_bytes(cmd[head_pos_pkg::SIDE_BIT], id_length_code);
    end
  end

  // Idle index counter; any start or fresh head load restarts it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_cnt <= 4'h0;
    end else if (start_wr || busy || !head_engage_output) begin
      idle_cnt <= 4'h0;
    end else if (index_pulse) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // Force-interrupt conditions and the ready edge they watch.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      force_cond <= 4'h0;
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready;
      if (force_wr) begin
        force_cond <= wdata[3:0];
      end else if (start_wr) begin
        force_cond <= 4'h0;
      end
    end
  end

  // Completion interrupt; a new event beats the clear by status read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      completion_interrupt <= 1'b0;
    end else if (done_evt ||
                 (force_wr && wdata[head_pos_pkg::IMMED_BIT]) ||
                 (force_cond[head_pos_pkg::TO_RDY_BIT] && ready && !ready_q) ||
                 (force_cond[head_pos_pkg::TO_NRDY_BIT] && !ready && ready_q) ||
                 (force_cond[head_pos_pkg::INDEX_BIT] && index_pulse)) begin
      completion_interrupt <= 1'b1;
    end else if (status_rd || cmd_wr) begin
      completion_interrupt <= 1'b0;
    end
  end

  // Read data stand for one cycle after the read strobe only.
  always_ff @(posedge clk) begin
    if (sys_rst || !rd_strobe) begin
      rdata <= 8'h00;
    end else if (addr == head_pos_pkg::ADDR_CMD) begin
      rdata <= status;
    end else if (addr == head_pos_pkg::ADDR_TRACK) begin
      rdata <= track;
    end else if (addr == head_pos_pkg::ADDR_SECTOR) begin
      rdata <= sector;
    end else begin
      rdata <= data;
    end
  end

  // Helper counters that only the checks below read.
  logic [31:0] hi_cnt;
  logic [11:0] dir_age;
  logic dir_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi_cnt <= 32'h0;
      dir_age <= 12'h0;
      dir_q <= 1'b0;
    end else begin
      hi_cnt <= step_pulse ? hi_cnt + 32'h1 : 32'h0;
      dir_q <= direction;
      dir_age <= (direction != dir_q) ? 12'h0 : (dir_age == 12'hfff ? dir_age : dir_age + 12'h1);
    end
  end

  step_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(step_pulse) && !$past(force_wr) |-> hi_cnt == width_cyc)
    else $error("Step pulse width is wrong.");
  dir_setup_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(step_pulse) |-> dir_age >= head_pos_pkg::DIR_SETUP_CYC)
    else $error("Direction changed too close to a step.");
  medium_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    medium_enable |-> head_engage_output && head_engaged_input)
    else $error("Medium access without head loaded and engaged.");
  status_head_a: assert property (@(posedge clk) disable iff (sys_rst)
    status_rd && !cmd[7] && !cmd_wr |=> rdata[head_pos_pkg::ST_HEAD] == $past(head_on))
    else $error("Status bit 5 does not match head state.");
  head_unload_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_wr && !wdata[7] && wdata[3:2] == 2'h0 |=> !head_engage_output)
    else $error("Head not unloaded by command with both flags clear.");
  head_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_wr && (wdata[7] ? ready : wdata[head_pos_pkg::HEAD_BIT]) |=> head_engage_output)
    else $error("Head not loaded at command start.");
  side_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_wr && wdata[7] && ready |=> side_compare_value == $past(wdata[head_pos_pkg::SIDE_BIT]))
    else $error("Side compare value not taken from bit 3.");
  multi_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_wr && wdata[7] && ready |=> multi_record == $past(wdata[head_pos_pkg::MULTI_BIT]))
    else $error("Multiple record flag not taken from bit 4.");
  force_immed_a: assert property (@(posedge clk) disable iff (sys_rst)
    force_wr && wdata[head_pos_pkg::IMMED_BIT] |=> completion_interrupt && !busy)
    else $error("Immediate force interrupt did not fire.");
  step_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == head_pos_pkg::ST_PLAN && cmd[6:5] == 2'h1 |=> direction == $past(direction))
    else $error("Plain step changed direction.");

endmodule

// file: head_pos_pkg.sv
// Operation
// - Sector command bit 3 picks compared side
// - Length flag selects ID length-code byte mapping
// - Sector command bit 4 selects multiple records
// - Force interrupt bits 0-3 pick trigger conditions
// - Rate field sets step interval, test shortens
// - Step pulse 4 us double, 8 us single
// - Keep last step direction unless command changes
// - Direction high inward, stable 24 us first
// - Verify adds 30 ms settling, zero in test
// - Verify track match, good CRC ends cleanly
// - Matching track, bad CRC: flag, keep searching
// - Five revolutions without match sets seek error
// - Head load on h, verify end, read/write
// - Head unloads on h=v=0 or idle 15 index
// - Medium access only with load and engaged
// - Positioning status bit 5 shows load and engaged
// - Head flag/verify order of load, settle, engage
// - Read/write loads head, optional delay, waits engaged
// - Positioning command bit 2 is verify flag
package head_pos_pkg;

  // Register addresses on the plain register port.
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_TRACK = 2'h1;
  localparam logic [1:0] ADDR_SECTOR = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;

  // Command word fields.
  localparam int RATE_LO = 0;
  localparam int VERIFY_BIT = 2;
  localparam int HEAD_BIT = 3;
  localparam int UPDATE_BIT = 4;
  localparam int DELAY_BIT = 2;
  localparam int SIDE_BIT = 3;
  localparam int MULTI_BIT = 4;
  localparam int IMMED_BIT = 3;
  localparam int INDEX_BIT = 2;
  localparam int TO_NRDY_BIT = 1;
  localparam int TO_RDY_BIT = 0;

  // Status bits.
  localparam int ST_BUSY = 0;
  localparam int ST_CRC = 3;
  localparam int ST_SEEK = 4;
  localparam int ST_HEAD = 5;

  // Times in nanoseconds, as printed.
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned STEP_DD_NS = 4000;
  localparam int unsigned STEP_SD_NS = 8000;
  localparam int unsigned DIR_SETUP_NS = 24000;
  localparam int unsigned SETTLE_NS = 30000000;
  localparam int unsigned RATE_N0_NS = 6000000;
  localparam int unsigned RATE_N1_NS = 12000000;
  localparam int unsigned RATE_N2_NS = 20000000;
  localparam int unsigned RATE_N3_NS = 30000000;
  localparam int unsigned RATE_T0_NS = 368000;
  localparam int unsigned RATE_T1_NS = 380000;
  localparam int unsigned RATE_T2_NS = 396000;
  localparam int unsigned RATE_T3_NS = 416000;

  // Least times round up to whole cycles.
  function automatic int unsigned cycles_min(input int unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int unsigned STEP_DD_CYC = cycles_min(STEP_DD_NS);
  localparam int unsigned STEP_SD_CYC = cycles_min(STEP_SD_NS);
  localparam int unsigned DIR_SETUP_CYC = cycles_min(DIR_SETUP_NS);

  // Counts of steps, revolutions and idle index pulses.
  localparam logic [7:0] MAX_STEPS = 8'hff;
  localparam logic [2:0] VERIFY_REVS = 3'h5;
  localparam logic [3:0] IDLE_INDEX = 4'hf;

  // Sector sizes in bytes for the ID length code.
  localparam logic [10:0] BYTES_128 = 11'h080;
  localparam logic [10:0] BYTES_256 = 11'h100;
  localparam logic [10:0] BYTES_512 = 11'h200;
  localparam logic [10:0] BYTES_1024 = 11'h400;

  // Maps a length code under the length flag to a byte count.
  function automatic logic [10:0] length_bytes(input logic flag, input logic [1:0] code);
    logic [10:0] res;
    res = BYTES_128;
    case (code)
      2'h0: res = flag ? BYTES_128 : BYTES_256;
      2'h1: res = flag ? BYTES_256 : BYTES_512;
      2'h2: res = flag ? BYTES_512 : BYTES_1024;
      default: res = flag ? BYTES_1024 : BYTES_128;
    endcase
    return res;
  endfunction

  // Controller sequencing states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PLAN = 4'h1,
    ST_DIR = 4'h2,
    ST_STEP_HI = 4'h3,
    ST_STEP_WAIT = 4'h4,
    ST_SETTLE = 4'h5,
    ST_ENGAGE = 4'h6,
    ST_VERIFY = 4'h7,
    ST_XFER = 4'h8
  } seq_state_t;

endpackage

// file: drive_model.sv
module drive_model #(
  parameter int REV = 1000,
  parameter int ENG = 100
) (
  // Clock, reset and controller lines.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic step_pulse,
  input wire logic direction,
  input wire logic head_engage_output,
  // Fault and format controls.
  input wire logic crc_bad,
  input wire logic track_off,
  input wire logic [1:0] len_code,
  // Drive answers.
  output logic track_zero,
  output logic index_pulse,
  output logic head_engaged_input,
  output logic id_valid,
  output logic [7:0] id_track,
  output logic id_crc_ok,
  output logic [1:0] id_length_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cyl;
  logic step_q;
  logic id_now;
  int rev;
  int eng;
  assign id_now = (rev == REV / 2);
  // ID lines hold only with their pulse, so stale values are inverted each cycle.
  always_ff @(posedge clk) begin
    step_q <= step_pulse;
    rev <= (sys_rst || rev == REV - 1) ? 0 : rev + 1;
    cyl <= sys_rst ? 8'h00 : (step_pulse && !step_q) ? cyl + (direction ? 8'h01 : 8'hff) : cyl;
    index_pulse <= (rev == 0);
    id_valid <= id_now;
    id_track <= id_now ? cyl ^ {8{track_off}} : ~id_track;
    id_crc_ok <= id_now ? !crc_bad : !id_crc_ok;
    id_length_code <= id_now ? len_code : ~id_length_code;
    eng <= !head_engage_output ? 0 : (eng < ENG) ? eng + 1 : eng;
  end
  // The one-shot restarts whenever the head load output drops.
  assign head_engaged_input = (eng == ENG);
  assign track_zero = (cyl == 8'h00);
endmodule

// file: tb_floppy_step_head_load_control.sv
module tb_floppy_step_head_load_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RN[4] = '{1000, 1100, 1200, 1300};
  localparam int unsigned RT[4] = '{500, 510, 520, 530};
  logic clk = 1'b0, sys_rst = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0, test_n = 1'b1;
  logic density_select_input = 1'b0, ready = 1'b1, xfer_done = 1'b0, crc_bad = 1'b0;
  logic track_off = 1'b0, dir_q, step_pulse, direction, head_engage_output, medium_enable;
  logic completion_interrupt, side_compare_value, multi_record, track_zero, index_pulse;
  logic head_engaged_input, id_valid, id_crc_ok;
  logic [1:0] addr = 2'h0, len_code = 2'h3, id_length_code;
  logic [7:0] wdata = 8'h00, rdata, id_track, st;
  logic [10:0] sector_bytes;
  int error_cnt = 0, checked = 0, dir_age = 0, n, w;
  always #5 clk = ~clk;
  // Cycles since the direction line last moved.
  always @(posedge clk) begin
    dir_q <= direction;
    dir_age <= (direction !== dir_q) ? 0 : dir_age + 1;
  end
  floppy_step_head_load_control #(.SETTLE_CYC(50), .RATE_N0_CYC(RN[0]), .RATE_N1_CYC(RN[1]),
    .RATE_N2_CYC(RN[2]), .RATE_N3_CYC(RN[3]), .RATE_T0_CYC(RT[0]), .RATE_T1_CYC(RT[1]),
    .RATE_T2_CYC(RT[2]), .RATE_T3_CYC(RT[3])) i_dut (.clk, .sys_rst, .addr, .wdata, .wr_strobe,
    .rd_strobe, .rdata, .test_n, .density_select_input, .ready, .index_pulse, .track_zero,
    .head_engaged_input, .id_valid, .id_track, .id_crc_ok, .id_length_code, .xfer_done,
    .step_pulse, .direction, .head_engage_output, .completion_interrupt, .medium_enable,
    .side_compare_value, .multi_record, .sector_bytes);
  drive_model i_drive (.clk, .sys_rst, .step_pulse, .direction, .head_engage_output, .crc_bad,
    .track_off, .len_code, .track_zero, .index_pulse, .head_engaged_input, .id_valid,
    .id_track, .id_crc_ok, .id_length_code);
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a level; n returns the cycles spent.
  task automatic wait_lv(ref logic s, input logic v, input int lim);
    for (n = 0; s !== v; n++) begin
      if (n >= lim) begin
        chk("wait bound", 11'h000, 11'h001);
        complete_run();
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 st = rdata;
  endtask
  // Rate codes in both modes, alternating direction, ending with a plain step.
  task automatic steps();
    for (int i = 0; i < 9; i++) begin
      test_n <= i[2];
      density_select_input <= i[0];
      wr(2'h0, (i == 8) ? 8'h30 : (i[0] ? 8'h58 : 8'h70) | 8'(i[1:0]));
      wait_lv(step_pulse, 1'b1, 4000);
      chk("dir setup", 11'h001, 11'(dir_age >= 2400));
      chk("direction", 11'(i[0] || i == 8), 11'(direction));
      chk("head load", 11'(i[0]), 11'(head_engage_output));
      wait_lv(step_pulse, 1'b0, 1000);
      w = n;
      chk("step width", i[0] ? 11'd800 : 11'd400, 11'(w));
      wait_lv(completion_interrupt, 1'b1, 3000);
      w += n;
      n = i[2] ? RN[i % 4] : RT[i % 4];
      chk("interval", 11'h001, 11'(w >= n && w <= n + 820));
      rd(2'h0);
      chk("status head", 11'(i[0]), 11'(st[5]));
    end
    // Restore from track one steps outward and zeroes the track register.
    wr(2'h0, 8'h00);
    wait_lv(completion_interrupt, 1'b1, 8000);
    chk("restore dir", 11'h000, 11'(direction));
    rd(2'h1);
    chk("restore track", 11'h000, 11'(st));
  endtask
  // Clean, bad then good CRC, and wrong track; then idle unload.
  task automatic verify();
    test_n <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      crc_bad <= (k == 1);
      track_off <= (k == 2);
      wr(2'h0, k[0] ? 8'h74 : 8'h54);
      wait_lv(step_pulse, 1'b1, 4000);
      chk("late load", 11'(k != 0), 11'(head_engage_output));
      if (k == 1) begin
        // Past the verify entry, let one bad ID through before healing it.
        repeat (1000) @(posedge clk);
        wait_lv(id_valid, 1'b1, 1100);
        crc_bad <= 1'b0;
      end
      wait_lv(completion_interrupt, 1'b1, 8000);
      chk("end load", 11'h001, 11'(head_engage_output));
      rd(2'h0);
      chk("verify status", 11'({k == 2, k == 1}), 11'(st[4:3]));
    end
    for (w = 0; head_engage_output === 1'b1 && w < 16; w += index_pulse) begin
      @(posedge clk);
      #1;
    end
    chk("idle index", 11'd15, 11'(w));
  endtask
  task automatic rw();
    for (int k = 0; k < 2; k++) begin
      wr(2'h0, k ? 8'h84 : 8'h98);
      @(posedge clk);
      #1;
      chk("rw load", 11'h001, 11'(head_engage_output));
      chk("no access", 11'h000, 11'(medium_enable));
      wait_lv(head_engaged_input, 1'b1, 300);
      wait_lv(medium_enable, 1'b1, 200);
      chk("side", 11'(!k), 11'(side_compare_value));
      chk("multi", 11'(!k), 11'(multi_record));
      wait_lv(id_valid, 1'b1, 1100);
      @(posedge clk);
      #1;
      chk("bytes", k ? 11'h080 : 11'h400, sector_bytes);
      xfer_done <= 1'b1;
      @(posedge clk);
      xfer_done <= 1'b0;
      wait_lv(completion_interrupt, 1'b1, 20);
      rd(2'h0);
    end
  endtask
  // Immediate, index and both ready edges; a status read clears the flag.
  task automatic force_int();
    for (int k = 0; k < 4; k++) begin
      wr(2'h0, 8'hd0 | 8'(8 >> k));
      ready <= (k != 2);
      wait_lv(completion_interrupt, 1'b1, k == 1 ? 1100 : 3);
      rd(2'h0);
      chk("irq cleared", 11'h000, 11'(completion_interrupt));
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset bytes", 11'h100, sector_bytes);
    steps();
    verify();
    rw();
    force_int();
    complete_run();
  end
endmodule
